// [hw/ipma_params.svh]
`ifndef IPMA_PARAMS_SVH
`define IPMA_PARAMS_SVH

// Register byte offsets
`define IPMA_DATA_OFS 12'h0a4
`define IPMA_ACCESS_OFS 12'h0a8

// Access register fields
`define IPMA_PHY_ADDR_HI 15
`define IPMA_PHY_ADDR_LO 11
`define IPMA_REG_IDX_HI 10
`define IPMA_REG_IDX_LO 6
`define IPMA_WNR_BIT 1
`define IPMA_BUSY_BIT 0

// Data register field
`define IPMA_DATA_HI 15
`define IPMA_DATA_LO 0

// Reset values
`define IPMA_PHY_ADDR_RST 5'h00
`define IPMA_REG_IDX_RST 5'h00
`define IPMA_DATA_RST 16'h0000
`define IPMA_RDATA_RST 32'h0000_0000

// Read data returned when the addressed PHY is never driven
`define IPMA_NO_PHY_DATA 16'hffff

// Management clock timing
`define IPMA_CLK_PERIOD_NS 5
`define IPMA_MDC_HALF_MIN_NS 200
`define IPMA_MDC_HALF_CYC ((`IPMA_MDC_HALF_MIN_NS + `IPMA_CLK_PERIOD_NS - 1) / `IPMA_CLK_PERIOD_NS)

// Serial frame layout, bit 0 is the first bit on the wire
`define IPMA_FRAME_BITS 64
`define IPMA_TA_FIRST 46
`define IPMA_DATA_FIRST 48
`define IPMA_PREAMBLE 32'hffff_ffff
`define IPMA_START_CODE 2'h1
`define IPMA_OP_WRITE 2'h1
`define IPMA_OP_READ 2'h2
`define IPMA_TA_WRITE 2'h2

`endif

// [hw/ipma_pkg.sv]
package ipma_pkg;

  typedef enum logic [0:0] {
    ENG_IDLE = 1'b0,
    ENG_SHIFT = 1'b1
  } ipma_eng_state_type;

  typedef logic [4:0] ipma_addr5_type;
  typedef logic [15:0] ipma_word_type;

endpackage

// [hw/ipma_mgmt_if.sv]
`timescale 1ns/1ps
interface ipma_mgmt_if;
  logic go;
  logic wr;
  ipma_pkg::ipma_addr5_type phyAddr;
  ipma_pkg::ipma_addr5_type regIdx;
  ipma_pkg::ipma_word_type wrData;
  logic done;
  ipma_pkg::ipma_word_type rdData;

  modport ctl (
    output go,
    output wr,
    output phyAddr,
    output regIdx,
    output wrData,
    input done,
    input rdData
  );

  modport eng (
    input go,
    input wr,
    input phyAddr,
    input regIdx,
    input wrData,
    output done,
    output rdData
  );
endinterface

// [hw/ipma_mdio_engine.sv]
`timescale 1ns/1ps
`include "ipma_params.svh"
module ipma_mdio_engine #(
  parameter int HALF_CYC = `IPMA_MDC_HALF_CYC
) (
  input wire logic mclk,
  input wire logic rst_b,
  ipma_mgmt_if.eng mgmt,
  input wire logic mdioIn,
  output logic mdcQ,
  output logic mdioOutQ,
  output logic mdioOeQ
);
  localparam int CW = $clog2(HALF_CYC + 1);
  localparam logic [CW-1:0] HALF_LAST = CW'(HALF_CYC - 1);
  localparam logic [5:0] LAST_BIT = 6'(`IPMA_FRAME_BITS - 1);
  localparam logic [5:0] TA_FIRST = 6'(`IPMA_TA_FIRST);
  localparam logic [5:0] DATA_FIRST = 6'(`IPMA_DATA_FIRST);

  ipma_pkg::ipma_eng_state_type state_q;
  logic [`IPMA_FRAME_BITS-1:0] frame_q;
  logic [5:0] bitIdx_q;
  logic [CW-1:0] halfCnt_q;
  logic isWr_q;
  logic done_q;
  logic [15:0] rdShift_q;
  logic sync1_q, sync2_q, sync3_q, mdioFilt_q;
  logic [5:0] nextIdx;

  assign nextIdx = bitIdx_q + 6'h01;
  assign mgmt.done = done_q;
  assign mgmt.rdData = rdShift_q;

  // Pin input: a change counts once the second and third stage agree
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      sync3_q <= 1'b1;
      mdioFilt_q <= 1'b1;
    end else begin
      sync1_q <= mdioIn;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      if (sync2_q == sync3_q) begin
        mdioFilt_q <= sync3_q;
      end
    end
  end

  // Frame: preamble, start, opcode, PHY, register, turnaround, data
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ipma_pkg::ENG_IDLE;
      frame_q <= '0;
      bitIdx_q <= 6'h00;
      halfCnt_q <= '0;
      isWr_q <= 1'b0;
      done_q <= 1'b0;
      rdShift_q <= 16'h0000;
      mdcQ <= 1'b0;
      mdioOutQ <= 1'b1;
      mdioOeQ <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        ipma_pkg::ENG_IDLE: begin
          if (mgmt.go) begin
            frame_q <= {`IPMA_PREAMBLE, `IPMA_START_CODE,
                        (mgmt.wr ? `IPMA_OP_WRITE : `IPMA_OP_READ),
                        mgmt.phyAddr, mgmt.regIdx, `IPMA_TA_WRITE, mgmt.wrData};
            isWr_q <= mgmt.wr;
            bitIdx_q <= 6'h00;
            halfCnt_q <= '0;
            mdcQ <= 1'b0;
            mdioOutQ <= 1'b1;
            mdioOeQ <= 1'b1;
            state_q <= ipma_pkg::ENG_SHIFT;
          end
        end
        ipma_pkg::ENG_SHIFT: begin
          if (halfCnt_q == HALF_LAST) begin
            halfCnt_q <= '0;
            if (!mdcQ) begin
              mdcQ <= 1'b1;
              // PHY drives data after turnaround; sample on rising edge
              if (!isWr_q && bitIdx_q >= DATA_FIRST) begin
                rdShift_q <= {rdShift_q[14:0], mdioFilt_q};
              end
            end else begin
              mdcQ <= 1'b0;
              if (bitIdx_q == LAST_BIT) begin
                mdioOeQ <= 1'b0;
                mdioOutQ <= 1'b1;
                done_q <= 1'b1;
                state_q <= ipma_pkg::ENG_IDLE;
              end else begin
                bitIdx_q <= nextIdx;
                frame_q <= {frame_q[`IPMA_FRAME_BITS-2:0], 1'b0};
                mdioOutQ <= frame_q[`IPMA_FRAME_BITS-2];
                // Release the line for the PHY on reads from turnaround on
                mdioOeQ <= isWr_q || (nextIdx < TA_FIRST);
              end
            end
          end else begin
            halfCnt_q <= halfCnt_q + CW'(1);
          end
        end
        default: begin
          state_q <= ipma_pkg::ENG_IDLE;
        end
      endcase
    end
  end
endmodule

// [hw/ipma_indirect_phy_mgmt.sv]
`timescale 1ns/1ps
`include "ipma_params.svh"
module ipma_indirect_phy_mgmt #(
  parameter int ADDR_W = 12,
  parameter int HALF_CYC = `IPMA_MDC_HALF_CYC
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] busAddr,
  input wire logic [31:0] busWrData,
  input wire logic busWrEn,
  input wire logic busRdEn,
  output logic [31:0] busRdData,
  input wire logic [4:0] emuPhyAddr,
  input wire logic mdioIn,
  output logic mdc,
  output logic mdioOut,
  output logic mdioOe
);
  localparam logic [ADDR_W-1:0] DATA_OFS = ADDR_W'(`IPMA_DATA_OFS);
  localparam logic [ADDR_W-1:0] ACCESS_OFS = ADDR_W'(`IPMA_ACCESS_OFS);

  ipma_mgmt_if mgmt ();

  logic [4:0] phyAddr_q;
  logic [4:0] regIdx_q;
  logic wnr_q;
  logic busy_q;
  logic launch_q;
  logic [15:0] wrWord_q;
  logic [15:0] phyWord_q;
  logic wrAccess;
  logic wrDataReg;
  logic emuHit;
  logic skip;
  logic [31:0] rdMux;

  assign wrAccess = busWrEn && (busAddr == ACCESS_OFS);
  assign wrDataReg = busWrEn && (busAddr == DATA_OFS);
  assign emuHit = (phyAddr_q == emuPhyAddr);
  // Emulated PHY lives elsewhere; its address is never put on the line
  assign skip = launch_q && emuHit;

  assign mgmt.go = launch_q && !emuHit;
  assign mgmt.wr = wnr_q;
  assign mgmt.phyAddr = phyAddr_q;
  assign mgmt.regIdx = regIdx_q;
  assign mgmt.wrData = wrWord_q;

  // A write while busy is dropped so the running frame keeps its fields
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      phyAddr_q <= `IPMA_PHY_ADDR_RST;
      regIdx_q <= `IPMA_REG_IDX_RST;
      wnr_q <= 1'b0;
    end else if (wrAccess && !busy_q) begin
      phyAddr_q <= busWrData[`IPMA_PHY_ADDR_HI:`IPMA_PHY_ADDR_LO];
      regIdx_q <= busWrData[`IPMA_REG_IDX_HI:`IPMA_REG_IDX_LO];
      wnr_q <= busWrData[`IPMA_WNR_BIT];
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      launch_q <= 1'b0;
    end else begin
      launch_q <= wrAccess && !busy_q;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
    end else if (wrAccess && !busy_q) begin
      busy_q <= 1'b1;
    end else if (mgmt.done || skip) begin
      busy_q <= 1'b0;
    end
  end

  // Software keeps this steady during a write transfer
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wrWord_q <= `IPMA_DATA_RST;
    end else if (wrDataReg) begin
      wrWord_q <= busWrData[`IPMA_DATA_HI:`IPMA_DATA_LO];
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      phyWord_q <= `IPMA_DATA_RST;
    end else if (mgmt.done && !wnr_q) begin
      phyWord_q <= mgmt.rdData;
    end else if (skip && !wnr_q) begin
      phyWord_q <= `IPMA_NO_PHY_DATA;
    end
  end

  always_comb begin
    rdMux = `IPMA_RDATA_RST;
    if (busAddr == DATA_OFS) begin
      rdMux[`IPMA_DATA_HI:`IPMA_DATA_LO] = wnr_q ? wrWord_q : phyWord_q;
    end else if (busAddr == ACCESS_OFS) begin
      rdMux[`IPMA_PHY_ADDR_HI:`IPMA_PHY_ADDR_LO] = phyAddr_q;
      rdMux[`IPMA_REG_IDX_HI:`IPMA_REG_IDX_LO] = regIdx_q;
      rdMux[`IPMA_WNR_BIT] = wnr_q;
      rdMux[`IPMA_BUSY_BIT] = busy_q;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      busRdData <= `IPMA_RDATA_RST;
    end else if (busRdEn) begin
      busRdData <= rdMux;
    end else begin
      busRdData <= `IPMA_RDATA_RST;
    end
  end

  ipma_mdio_engine #(
    .HALF_CYC(HALF_CYC)
  ) u_engine (
    .mclk(mclk),
    .rst_b(rst_b),
    .mgmt(mgmt.eng),
    .mdioIn(mdioIn),
    .mdcQ(mdc),
    .mdioOutQ(mdioOut),
    .mdioOeQ(mdioOe)
  );

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  property p_launch;
    wrAccess && !busy_q |=> launch_q && busy_q;
  endproperty
  a_launch: assert property (p_launch) else $error("access write did not launch");

  property p_phy_addr;
    wrAccess && !busy_q |=> phyAddr_q == $past(busWrData[15:11]);
  endproperty
  a_phy_addr: assert property (p_phy_addr) else $error("PHY address not stored");

  property p_reg_idx;
    wrAccess && !busy_q |=> regIdx_q == $past(busWrData[10:6]);
  endproperty
  a_reg_idx: assert property (p_reg_idx) else $error("register index not stored");

  property p_dir;
    wrAccess && !busy_q |=> mgmt.wr == $past(busWrData[1]);
  endproperty
  a_dir: assert property (p_dir) else $error("direction bit not passed on");

  property p_busy_hold;
    busy_q && !mgmt.done && !skip |=> busy_q;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");

  property p_busy_clear;
    mgmt.done || skip |=> !busy_q;
  endproperty
  a_busy_clear: assert property (p_busy_clear) else $error("busy not cleared");

  property p_busy_read;
    busRdEn && busAddr == ACCESS_OFS |=> busRdData[0] == $past(busy_q) && busRdData[31:16] == 16'h0000;
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("busy readback wrong");

  property p_no_emu;
    mgmt.go |-> phyAddr_q != emuPhyAddr;
  endproperty
  a_no_emu: assert property (p_no_emu) else $error("emulated PHY addressed");

  property p_data_upper;
    busRdEn && busAddr == DATA_OFS |=> busRdData[31:16] == 16'h0000;
  endproperty
  a_data_upper: assert property (p_data_upper) else $error("data upper bits not zero");

  property p_data_mux;
    busRdEn && busAddr == DATA_OFS |=> busRdData[15:0] == ($past(wnr_q) ? $past(wrWord_q) : $past(phyWord_q));
  endproperty
  a_data_mux: assert property (p_data_mux) else $error("data readback source wrong");

  property p_rd_latch;
    mgmt.done && !wnr_q |=> phyWord_q == $past(mgmt.rdData) && !busy_q;
  endproperty
  a_rd_latch: assert property (p_rd_latch) else $error("read data not latched");

  property p_go_to_line;
    mgmt.go |=> mdioOe && !mdc;
  endproperty
  a_go_to_line: assert property (p_go_to_line) else $error("frame did not start");

  property p_rd_strobe_only;
    !busRdEn |=> busRdData == 32'h0000_0000;
  endproperty
  a_rd_strobe_only: assert property (p_rd_strobe_only) else $error("read data outside slot");

  property p_launch_pulse;
    launch_q |=> !launch_q;
  endproperty
  a_launch_pulse: assert property (p_launch_pulse) else $error("launch longer than one cycle");

  property p_no_relaunch;
    busy_q |=> !launch_q;
  endproperty
  a_no_relaunch: assert property (p_no_relaunch) else $error("second launch while busy");

  property p_busy_rise;
    $rose(busy_q) |-> $past(wrAccess);
  endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy set without access write");

  property p_busy_fall;
    $fell(busy_q) |-> $past(mgmt.done || skip);
  endproperty
  a_busy_fall: assert property (p_busy_fall) else $error("busy cleared before transfer end");

  property p_go_busy;
    mgmt.go |-> busy_q && !mdioOe;
  endproperty
  a_go_busy: assert property (p_go_busy) else $error("launch without busy set");

  property p_done_busy;
    mgmt.done |-> busy_q && !launch_q;
  endproperty
  a_done_busy: assert property (p_done_busy) else $error("transfer end while not busy");

  property p_data_write;
    wrDataReg |=> wrWord_q == $past(busWrData[15:0]);
  endproperty
  a_data_write: assert property (p_data_write) else $error("data word not stored");

  property p_data_hold;
    !wrDataReg |=> $stable(wrWord_q);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data word changed without write");

  property p_phy_word_hold;
    !mgmt.done && !skip |=> $stable(phyWord_q);
  endproperty
  a_phy_word_hold: assert property (p_phy_word_hold) else $error("read word changed outside transfer end");

  property p_wr_keeps_read;
    mgmt.done && wnr_q |=> $stable(phyWord_q);
  endproperty
  a_wr_keeps_read: assert property (p_wr_keeps_read) else $error("write transfer disturbed read word");

  property p_skip_data;
    skip && !wnr_q |=> phyWord_q == `IPMA_NO_PHY_DATA;
  endproperty
  a_skip_data: assert property (p_skip_data) else $error("skipped read word wrong");

  property p_skip_quiet;
    skip |=> !mdioOe && !busy_q;
  endproperty
  a_skip_quiet: assert property (p_skip_quiet) else $error("skipped access touched the line");

  property p_preamble_start;
    mgmt.go |=> mdioOut;
  endproperty
  a_preamble_start: assert property (p_preamble_start) else $error("frame did not open with a one");

  property p_idle_oe;
    !busy_q |-> !mdioOe;
  endproperty
  a_idle_oe: assert property (p_idle_oe) else $error("line driven while idle");

  property p_idle_mdc;
    !busy_q |-> !mdc;
  endproperty
  a_idle_mdc: assert property (p_idle_mdc) else $error("management clock high while idle");

  property p_access_fields;
    busRdEn && busAddr == ACCESS_OFS |=> busRdData[15:6] == $past({phyAddr_q, regIdx_q})
      && busRdData[1] == $past(wnr_q) && busRdData[5:2] == 4'h0;
  endproperty
  a_access_fields: assert property (p_access_fields) else $error("access fields readback wrong");

  property p_unmapped;
    busRdEn && busAddr != DATA_OFS && busAddr != ACCESS_OFS |=> busRdData == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  c_write: cover property (mgmt.go && mgmt.wr ##1 busy_q [*3] ##[1:1000] mgmt.done);
  c_read: cover property (mgmt.go && !mgmt.wr ##[1:1000] mgmt.done);
  c_skip: cover property (skip ##1 !busy_q);
  c_busy_poll: cover property (busRdEn && busAddr == ACCESS_OFS && busy_q);
endmodule

// [bench/ipma_phy_model.sv]
`timescale 1ns/1ps
module ipma_phy_model (
  input wire logic mdc,
  input wire logic mdioOut,
  input wire logic mdioOe,
  output logic mdioIn,
  output int frames,
  output int badFrames
);
  logic [15:0] mem [0:1023];
  logic [45:0] hdr;
  logic [15:0] wd;
  logic drv;
  logic bitOut;
  int n;

  // Pull-up holds the line high whenever nobody drives it
  assign mdioIn = mdioOe ? mdioOut : (drv ? bitOut : 1'b1);

  initial begin
    for (int i = 0; i < 1024; i++) begin
      mem[i] = 16'ha500 ^ 16'(i);
    end
    frames = 0;
    badFrames = 0;
    drv = 1'b0;
    bitOut = 1'b1;
    n = 0;
  end

  always @(posedge mdioOe) begin
    n = 0;
  end

  // Drives just after a rise so each bit has a full period to settle
  always @(posedge mdc) begin
    if (n < 46) begin
      hdr = {hdr[44:0], mdioOut};
    end else if (n >= 48 && hdr[11:10] == 2'b01) begin
      wd = {wd[14:0], mdioOut};
    end
    if (n == 46 && hdr[11:10] == 2'b10) begin
      drv = 1'b1;
      bitOut = 1'b0;
    end
    if (n >= 47 && n < 63 && drv) begin
      bitOut = mem[hdr[9:0]][62-n];
    end
    if (n == 63) begin
      drv = 1'b0;
      frames++;
      if (hdr[45:12] !== {32'hffff_ffff, 2'b01}) begin
        badFrames++;
      end
      if (hdr[11:10] == 2'b01) begin
        mem[hdr[9:0]] = wd;
      end
    end
    n++;
  end
endmodule

// [bench/indirect_phy_mgmt_access_tb_top.sv]
`timescale 1ns/1ps
module indirect_phy_mgmt_access_tb_top;
  logic mclk;
  logic rst_b;
  logic [11:0] busAddr;
  logic [31:0] busWrData;
  logic busWrEn;
  logic busRdEn;
  logic [31:0] busRdData;
  logic [4:0] emuPhyAddr;
  logic mdioIn;
  logic mdc;
  logic mdioOut;
  logic mdioOe;
  int frames;
  int badFrames;
  int errCount;
  int nTests;

  ipma_indirect_phy_mgmt #(.ADDR_W(12), .HALF_CYC(4)) uut (
    .mclk(mclk),
    .rst_b(rst_b),
    .busAddr(busAddr),
    .busWrData(busWrData),
    .busWrEn(busWrEn),
    .busRdEn(busRdEn),
    .busRdData(busRdData),
    .emuPhyAddr(emuPhyAddr),
    .mdioIn(mdioIn),
    .mdc(mdc),
    .mdioOut(mdioOut),
    .mdioOe(mdioOe)
  );

  ipma_phy_model phyModel (
    .mdc(mdc),
    .mdioOut(mdioOut),
    .mdioOe(mdioOe),
    .mdioIn(mdioIn),
    .frames(frames),
    .badFrames(badFrames)
  );

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    nTests++;
    if (g !== e) begin
      errCount++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic busWr(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    busAddr <= a;
    busWrData <= d;
    busWrEn <= 1'b1;
    @(posedge mclk);
    busWrEn <= 1'b0;
  endtask

  task automatic busRd(input logic [11:0] a, output logic [31:0] d);
    @(posedge mclk);
    busAddr <= a;
    busRdEn <= 1'b1;
    @(posedge mclk);
    busRdEn <= 1'b0;
    #1;
    d = busRdData;
  endtask

  // Poll bound covers one full frame at the reduced divider
  task automatic waitIdle();
    logic [31:0] v;
    int k;
    k = 0;
    v = 32'h0000_0001;
    while (v[0] !== 1'b0 && k < 400) begin
      busRd(12'h0a8, v);
      k++;
    end
    chk("busy", 32'h0000_0000, {31'h0000_0000, v[0]});
  endtask

  // Reserved and busy bits set on purpose; reserved bits must read back clear, busy reads back as b
  // A skipped access has already dropped busy by the time the readback lands
  task automatic startAcc(input logic [4:0] p, input logic [4:0] r, input logic w, input logic b);
    logic [31:0] v;
    busWr(12'h0a8, {16'hffff, p, r, 4'hf, w, 1'b1});
    busRd(12'h0a8, v);
    chk("access", {16'h0000, p, r, 4'h0, w, b}, v);
  endtask

  task automatic tReset();
    logic [31:0] v;
    busRd(12'h0a8, v);
    chk("access reset", 32'h0000_0000, v);
    busRd(12'h0a4, v);
    chk("data reset", 32'h0000_0000, v);
    busRd(12'h0a0, v);
    chk("unmapped", 32'h0000_0000, v);
    chk("idle pins", 32'h0000_0001, {29'h0000_0000, mdc, mdioOe, mdioOut});
    $display("tReset done");
  endtask

  task automatic tWrite(input logic [4:0] p, input logic [4:0] r, input logic [15:0] d);
    logic [31:0] v;
    int f0;
    f0 = frames;
    busWr(12'h0a4, {16'hffff, d});
    startAcc(p, r, 1'b1, 1'b1);
    waitIdle();
    chk("frames", f0 + 1, frames);
    chk("phy mem", {16'h0000, d}, {16'h0000, phyModel.mem[{p, r}]});
    busRd(12'h0a4, v);
    chk("data back", {16'h0000, d}, v);
    $display("tWrite done");
  endtask

  task automatic tRead(input logic [4:0] p, input logic [4:0] r, input logic [15:0] e, input int nf);
    logic [31:0] v;
    int f0;
    f0 = frames;
    startAcc(p, r, 1'b0, nf != 0);
    waitIdle();
    chk("frames", f0 + nf, frames);
    busRd(12'h0a4, v);
    chk("read data", {16'h0000, e}, v);
    $display("tRead done");
  endtask

  task automatic closeOut();
    $display("checks %0d mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    errCount++;
    closeOut();
  end

  initial begin
    errCount = 0;
    nTests = 0;
    rst_b = 1'b0;
    busAddr = 12'h000;
    busWrData = 32'h0000_0000;
    busWrEn = 1'b0;
    busRdEn = 1'b0;
    emuPhyAddr = 5'h07;
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    tReset();
    tWrite(5'h1f, 5'h15, 16'hbeef);
    tRead(5'h03, 5'h02, 16'ha500 ^ 16'h0062, 1);
    tRead(5'h1f, 5'h15, 16'hbeef, 1);
    tRead(5'h07, 5'h01, 16'hffff, 0);
    chk("frame format", 32'h0000_0000, 32'(badFrames));
    closeOut();
  end
endmodule
